// *** core/ccrb_pkg.sv ***
// Package for the charger configuration register bank: map, layouts, reset values, states
package ccrb_pkg;

  // Seven-bit serial slave address (write 0x28, read 0x29 on the wire)
  localparam logic [6:0] DEV_ADDR = 7'h14;

  // Register byte addresses
  localparam logic [7:0] REG_ID = 8'h00;
  localparam logic [7:0] REG_REV = 8'h01;
  localparam logic [7:0] REG_INPUT = 8'h02;
  localparam logic [7:0] REG_TERM = 8'h03;
  localparam logic [7:0] REG_CHG = 8'h04;
  localparam logic [7:0] REG_VTH = 8'h05;
  localparam logic [7:0] REG_TMR = 8'h06;
  localparam logic [7:0] REG_FUNA = 8'h07;
  localparam logic [7:0] REG_FUNB = 8'h08;
  localparam logic [7:0] REG_EVEN = 8'h09;
  localparam logic [7:0] REG_EVPEND = 8'h0A;
  localparam logic [7:0] REG_STA = 8'h0B;
  localparam logic [7:0] REG_STB = 8'h0C;
  localparam logic [7:0] REG_FAULT = 8'h0D;
  localparam logic [7:0] REG_SHORT = 8'h10;

  // Values after reset
  localparam logic [7:0] RST_INPUT = 8'h00;
  localparam logic [7:0] RST_TERM = 8'h8D;
  localparam logic [7:0] RST_CHG = 8'h1E;
  localparam logic [7:0] RST_VTH = 8'h6B;
  localparam logic [7:0] RST_TMR = 8'h18;
  localparam logic [7:0] RST_FUNA = 8'h47;
  localparam logic [7:0] RST_EVEN = 8'h00;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [7:0] RST_SHORT = 8'h84;

  // Writable bit masks per register
  localparam logic [7:0] MSK_INPUT = 8'h1F;
  localparam logic [7:0] MSK_TERM = 8'hFF;
  localparam logic [7:0] MSK_CHG = 8'hDF;
  localparam logic [7:0] MSK_VTH = 8'h7F;
  localparam logic [7:0] MSK_TMR = 8'h3E;
  localparam logic [7:0] MSK_FUNA = 8'hF7;
  localparam logic [7:0] MSK_EVEN = 8'hFF;
  localparam logic [7:0] MSK_FAULT = 8'h0F;
  localparam logic [7:0] MSK_SHORT = 8'hE7;

  // Field positions
  localparam int CHG_C20_BIT = 7;
  localparam int CHG_C10_BIT = 6;
  localparam int CHG_HIGH_BIT = 5;
  localparam int TMR_KICK_BIT = 0;

  // Bit count of one serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // End-of-charge selection seen by the charger
  typedef enum logic [1:0] {
    EOC_FIXED = 2'h0,
    EOC_C10 = 2'h1,
    EOC_C20 = 2'h2
  } ccrb_eoc_t;

  // Serial slave states, one-hot
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_ACK_ADDR = 9'h004,
    S_SUB = 9'h008,
    S_ACK_SUB = 9'h010,
    S_WDATA = 9'h020,
    S_ACK_W = 9'h040,
    S_RDATA = 9'h080,
    S_ACK_R = 9'h100
  } ccrb_state_t;

endpackage : ccrb_pkg

// *** core/ccrb_top.sv ***
// Charger configuration register bank behind a two-wire serial slave port
`timescale 1ns/1ps

module ccrb_top
  import ccrb_pkg::*;
#(
  parameter logic [3:0] MAKER_CODE = 4'hA, // Arbitrary value
  parameter logic [3:0] MODEL_CODE = 4'h3, // Arbitrary value
  parameter logic [3:0] REV_CODE = 4'h2 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] event_pending_in,
  input wire logic [7:0] charger_state_a_in,
  input wire logic [7:0] charger_state_b_in,
  input wire logic [3:0] fault_set,
  output logic [3:0] input_current_limit,
  output logic [5:0] termination_voltage,
  output logic [1:0] termination_current,
  output ccrb_eoc_t end_of_charge_mode,
  output logic [2:0] fast_charge_current,
  output logic [1:0] trickle_current,
  output logic [1:0] recharge_threshold,
  output logic [1:0] dead_battery_threshold,
  output logic [2:0] weak_battery_threshold,
  output logic complete_timer_enable,
  output logic charge_timer_enable,
  output logic charge_timer_period,
  output logic watchdog_enable,
  output logic watchdog_period,
  output logic watchdog_kick,
  output logic temp_profile_enable,
  output logic peak_shutdown_disable,
  output logic battery_monitor_force,
  output logic thermistor_source_force,
  output logic end_of_charge_enable,
  output logic trickle_enable,
  output logic charger_enable,
  output logic [7:0] event_enable,
  output logic [3:0] fault_flags,
  output logic [2:0] short_timeout_sel,
  output logic [2:0] short_voltage_sel
);

  // Whole module state in one record
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    ccrb_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic rw;
    logic [7:0] sub;
    logic sda_low;
    logic kick;
    logic [7:0] r_input;
    logic [7:0] r_term;
    logic [7:0] r_chg;
    logic [7:0] r_vth;
    logic [7:0] r_tmr;
    logic [7:0] r_funa;
    logic [7:0] r_even;
    logic [7:0] r_fault;
    logic [7:0] r_short;
  } ccrb_st_t;

  ccrb_st_t st;
  ccrb_st_t next_st;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rd_val;
  logic wr_stb;

  // Filtered levels: a change counts once stages two and three agree
  assign scl_lvl = (st.scl_s[1] == st.scl_s[2]) ? st.scl_s[2] : st.scl_f;
  assign sda_lvl = (st.sda_s[1] == st.sda_s[2]) ? st.sda_s[2] : st.sda_f;
  assign scl_rise = scl_lvl & ~st.scl_f;
  assign scl_fall = ~scl_lvl & st.scl_f;
  // Start and stop are data edges while the clock stays high
  assign bus_start = st.scl_f & scl_lvl & st.sda_f & ~sda_lvl;
  assign bus_stop = st.scl_f & scl_lvl & ~st.sda_f & sda_lvl;

  // Read multiplexer on the current subaddress
  always_comb begin
    if (st.sub == REG_ID) begin
      rd_val = {MAKER_CODE, MODEL_CODE};
    end else if (st.sub == REG_REV) begin
      rd_val = {4'h0, REV_CODE};
    end else if (st.sub == REG_INPUT) begin
      rd_val = st.r_input;
    end else if (st.sub == REG_TERM) begin
      rd_val = st.r_term;
    end else if (st.sub == REG_CHG) begin
      rd_val = st.r_chg | (8'h01 << CHG_HIGH_BIT);
    end else if (st.sub == REG_VTH) begin
      rd_val = st.r_vth;
    end else if (st.sub == REG_TMR) begin
      rd_val = st.r_tmr; // Kick bit is write-only and reads zero
    end else if (st.sub == REG_FUNA) begin
      rd_val = st.r_funa;
    end else if (st.sub == REG_EVEN) begin
      rd_val = st.r_even;
    end else if (st.sub == REG_EVPEND) begin
      rd_val = event_pending_in;
    end else if (st.sub == REG_STA) begin
      rd_val = charger_state_a_in;
    end else if (st.sub == REG_STB) begin
      rd_val = charger_state_b_in & 8'hF7;
    end else if (st.sub == REG_FAULT) begin
      rd_val = st.r_fault;
    end else if (st.sub == REG_SHORT) begin
      rd_val = st.r_short;
    end else begin
      rd_val = 8'h00;
    end
  end

  // Next state: synchronisers, serial slave, register writes
  always_comb begin
    logic [7:0] fclr;
    fclr = 8'h00;
    next_st = st;
    wr_stb = 1'b0;
    next_st.kick = 1'b0;
    next_st.scl_s = {st.scl_s[1:0], scl_in};
    next_st.sda_s = {st.sda_s[1:0], sda_in};
    next_st.scl_f = scl_lvl;
    next_st.sda_f = sda_lvl;
    if (bus_start) begin
      next_st.state = S_ADDR;
      next_st.cnt = 4'h0;
      next_st.sda_low = 1'b0;
    end else if (bus_stop) begin
      next_st.state = S_IDLE;
      next_st.sda_low = 1'b0;
    end else begin
      // Sample on rising clock, in every receiving state
      if (scl_rise && st.state != S_IDLE) begin
        next_st.shreg = {st.shreg[6:0], sda_lvl};
        next_st.cnt = st.cnt + 4'h1;
      end
      // All line changes happen on the falling clock
      if (scl_fall) begin
        case (st.state)
          S_ADDR: begin
            if (st.cnt == BYTE_BITS) begin
              if (st.shreg[7:1] == DEV_ADDR) begin
                next_st.state = S_ACK_ADDR;
                next_st.rw = st.shreg[0];
                next_st.sda_low = 1'b1;
              end else begin
                next_st.state = S_IDLE; // Another slave's address
              end
            end
          end
          S_ACK_ADDR: begin
            next_st.cnt = 4'h0;
            if (st.rw) begin
              next_st.state = S_RDATA;
              next_st.tx = rd_val;
              next_st.sda_low = ~rd_val[7];
            end else begin
              next_st.state = S_SUB;
              next_st.sda_low = 1'b0;
            end
          end
          S_SUB: begin
            if (st.cnt == BYTE_BITS) begin
              next_st.sub = st.shreg;
              next_st.state = S_ACK_SUB;
              next_st.sda_low = 1'b1;
            end
          end
          S_ACK_SUB: begin
            next_st.state = S_WDATA;
            next_st.cnt = 4'h0;
            next_st.sda_low = 1'b0;
          end
          S_WDATA: begin
            if (st.cnt == BYTE_BITS) begin
              wr_stb = 1'b1;
              next_st.state = S_ACK_W;
              next_st.sda_low = 1'b1;
              // Only documented fields take the data
              if (st.sub == REG_INPUT) begin
                next_st.r_input = st.shreg & MSK_INPUT;
              end else if (st.sub == REG_TERM) begin
                next_st.r_term = st.shreg & MSK_TERM;
              end else if (st.sub == REG_CHG) begin
                next_st.r_chg = st.shreg & MSK_CHG;
              end else if (st.sub == REG_VTH) begin
                next_st.r_vth = st.shreg & MSK_VTH;
              end else if (st.sub == REG_TMR) begin
                next_st.r_tmr = st.shreg & MSK_TMR;
                next_st.kick = st.shreg[TMR_KICK_BIT];
              end else if (st.sub == REG_FUNA) begin
                next_st.r_funa = st.shreg & MSK_FUNA;
              end else if (st.sub == REG_EVEN) begin
                next_st.r_even = st.shreg & MSK_EVEN;
              end else if (st.sub == REG_FAULT) begin
                fclr = st.shreg & MSK_FAULT; // Write one clears
              end else if (st.sub == REG_SHORT) begin
                next_st.r_short = st.shreg & MSK_SHORT;
              end
            end
          end
          S_ACK_W: begin
            next_st.sub = st.sub + 8'h01;
            next_st.state = S_WDATA;
            next_st.cnt = 4'h0;
            next_st.sda_low = 1'b0;
          end
          S_RDATA: begin
            if (st.cnt == BYTE_BITS) begin
              next_st.sub = st.sub + 8'h01;
              next_st.state = S_ACK_R;
              next_st.sda_low = 1'b0;
            end else begin
              next_st.tx = {st.tx[6:0], 1'b0};
              next_st.sda_low = ~st.tx[6];
            end
          end
          S_ACK_R: begin
            // Host acknowledge low means another byte is wanted
            if (st.shreg[0]) begin
              next_st.state = S_IDLE;
              next_st.sda_low = 1'b0;
            end else begin
              next_st.state = S_RDATA;
              next_st.cnt = 4'h0;
              next_st.tx = rd_val;
              next_st.sda_low = ~rd_val[7];
            end
          end
          default: begin
            next_st.sda_low = 1'b0;
          end
        endcase
      end
    end
    // Hardware set wins over a clear in the same cycle
    next_st.r_fault = (st.r_fault & ~fclr) | {4'h0, fault_set};
  end

  // State register; reset stands for loss of input power
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.scl_s <= 3'h7;
      st.sda_s <= 3'h7;
      st.scl_f <= 1'b1;
      st.sda_f <= 1'b1;
      st.state <= S_IDLE;
      st.r_input <= RST_INPUT;
      st.r_term <= RST_TERM;
      st.r_chg <= RST_CHG;
      st.r_vth <= RST_VTH;
      st.r_tmr <= RST_TMR;
      st.r_funa <= RST_FUNA;
      st.r_even <= RST_EVEN;
      st.r_fault <= RST_FAULT;
      st.r_short <= RST_SHORT;
    end else begin
      st <= next_st;
    end
  end

  // Open-drain data line: drive low only
  assign sda_out = 1'b0;
  assign sda_oe = st.sda_low;

  // C/20 beats C/10 beats the fixed current
  assign end_of_charge_mode = st.r_chg[CHG_C20_BIT] ? EOC_C20 :
    (st.r_chg[CHG_C10_BIT] ? EOC_C10 : EOC_FIXED);

  // Field outputs straight from the registers
  assign input_current_limit = st.r_input[3:0];
  assign termination_voltage = st.r_term[7:2];
  assign termination_current = st.r_term[1:0];
  assign fast_charge_current = st.r_chg[4:2];
  assign trickle_current = st.r_chg[1:0];
  assign recharge_threshold = st.r_vth[6:5];
  assign dead_battery_threshold = st.r_vth[4:3];
  assign weak_battery_threshold = st.r_vth[2:0];
  assign complete_timer_enable = st.r_tmr[5];
  assign charge_timer_enable = st.r_tmr[4];
  assign charge_timer_period = st.r_tmr[3];
  assign watchdog_enable = st.r_tmr[2];
  assign watchdog_period = st.r_tmr[1];
  assign watchdog_kick = st.kick;
  assign temp_profile_enable = st.r_funa[7];
  assign peak_shutdown_disable = st.r_funa[6];
  assign battery_monitor_force = st.r_funa[5];
  assign thermistor_source_force = st.r_funa[4];
  assign end_of_charge_enable = st.r_funa[2];
  assign trickle_enable = st.r_funa[1];
  assign charger_enable = st.r_funa[0];
  assign event_enable = st.r_even;
  assign fault_flags = st.r_fault[3:0];
  assign short_timeout_sel = st.r_short[7:5];
  assign short_voltage_sel = st.r_short[2:0];

  // Checks on the register bank and the slave port
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_addr_match;
    st.state == S_ADDR && scl_fall && st.cnt == BYTE_BITS && st.shreg[7:1] == DEV_ADDR;
  endsequence

  sequence s_data_ack;
    st.state == S_ACK_W && scl_fall && !bus_start && !bus_stop;
  endsequence

  sequence s_kick_write;
    wr_stb && st.sub == REG_TMR && st.shreg[TMR_KICK_BIT];
  endsequence

  a_id_fixed: assert property (st.sub == REG_ID |-> rd_val == {MAKER_CODE, MODEL_CODE})
    else $error("identity read wrong");
  a_rev_upper_zero: assert property (st.sub == REG_REV |-> rd_val == {4'h0, REV_CODE})
    else $error("revision read wrong");
  a_limit_write: assert property (wr_stb && st.sub == REG_INPUT |=> input_current_limit == $past(st.shreg[3:0]))
    else $error("input limit not written");
  a_eoc_c20: assert property (st.r_chg[CHG_C20_BIT] |-> end_of_charge_mode == EOC_C20)
    else $error("C/20 priority lost");
  a_eoc_c10: assert property (!st.r_chg[CHG_C20_BIT] && st.r_chg[CHG_C10_BIT] |-> end_of_charge_mode == EOC_C10)
    else $error("C/10 selection lost");
  a_chg_bit_high: assert property (st.sub == REG_CHG |-> rd_val[CHG_HIGH_BIT])
    else $error("charge register bit five low");
  a_kick_pulse: assert property (s_kick_write |=> watchdog_kick ##1 !watchdog_kick)
    else $error("kick not a single pulse");
  a_unmapped_zero: assert property (st.sub > REG_FAULT && st.sub != REG_SHORT |-> rd_val == 8'h00)
    else $error("unmapped read not zero");
  a_addr_ack: assert property (s_addr_match |=> sda_oe && st.state == S_ACK_ADDR)
    else $error("own address not acknowledged");
  a_sub_increment: assert property (s_data_ack |=> st.sub == $past(st.sub) + 8'h01)
    else $error("subaddress not incremented");
  a_fault_set_wins: assert property (fault_set[0] |=> fault_flags[0])
    else $error("fault set lost to clear");

endmodule : ccrb_top

// *** dv/ccrb_host_model.sv ***
// Host bus master model for the two-wire port of the register bank
`timescale 1ns/1ps

module ccrb_host_model
  import ccrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl_out,
  output logic sda_low
);
  // Both lines released at start; the pull-up holds them high
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end

  // Six clocks per phase keeps every level past the slave's input filter
  task automatic phase();
    repeat (6) @(posedge clk_sys);
  endtask : phase

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_low <= 1'b0;
    phase();
    scl_out <= 1'b1;
    phase();
    sda_low <= 1'b1;
    phase();
    scl_out <= 1'b0;
    phase();
  endtask : start_cond

  // Stop: data rises while the clock is high, leaving the bus free
  task automatic stop_cond();
    sda_low <= 1'b1;
    phase();
    scl_out <= 1'b1;
    phase();
    sda_low <= 1'b0;
    phase();
  endtask : stop_cond

  // Nine clock pulses, MSB first; a one releases the line so the slave may answer
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~tx[i];
      phase();
      scl_out <= 1'b1;
      phase();
      rx[i] = sda_line;
      scl_out <= 1'b0;
      phase();
    end
  endtask : xfer

  // Write a run of bytes from a subaddress; ok is low if any byte went unacknowledged
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] data[$], output logic ok);
    logic [8:0] rx;
    ok = 1'b1;
    start_cond();
    xfer({dev, 1'b0, 1'b1}, rx);
    ok &= ~rx[0];
    if (ok) begin
      xfer({sub, 1'b1}, rx);
      ok &= ~rx[0];
      foreach (data[k]) begin
        xfer({data[k], 1'b1}, rx);
        ok &= ~rx[0];
      end
    end
    stop_cond();
  endtask : wr

  // Read n bytes from a subaddress; the last byte is refused to end the read
  task automatic rd(input logic [7:0] sub, input int n, output logic [7:0] data[$], output logic ok);
    logic [8:0] rx;
    data = {};
    ok = 1'b1;
    start_cond();
    xfer({DEV_ADDR, 1'b0, 1'b1}, rx);
    ok &= ~rx[0];
    xfer({sub, 1'b1}, rx);
    ok &= ~rx[0];
    start_cond();
    xfer({DEV_ADDR, 1'b1, 1'b1}, rx);
    ok &= ~rx[0];
    for (int k = 0; k < n; k++) begin
      xfer({8'hFF, k == n - 1}, rx);
      data.push_back(rx[8:1]);
    end
    stop_cond();
  endtask : rd
endmodule : ccrb_host_model

// *** dv/ccrb_top_tb_top.sv ***
// Self-checking testbench for the charger configuration register bank
`timescale 1ns/1ps

module ccrb_top_tb_top
  import ccrb_pkg::*;
();
  localparam logic [3:0] MAKER = 4'hA; // Arbitrary value
  localparam logic [3:0] MODEL = 4'h3; // Arbitrary value
  localparam logic [3:0] REV = 4'h2; // Arbitrary value
  localparam logic [7:0] WMSK [17] = '{8'h00, 8'h00, 8'h1F, 8'hFF, 8'hDF, 8'h7F, 8'h3E, 8'hF7, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'hE7};
  localparam logic [7:0] RSTV [17] = '{8'h00, 8'h00, 8'h00, 8'h8D, 8'h1E, 8'h6B, 8'h18, 8'h47, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84};
  localparam logic [7:0] FIXV [17] = '{{MAKER, MODEL}, {4'h0, REV}, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] PATS [4] = '{8'hFF, 8'h55, 8'hAA, 8'h00};

  logic clk_sys, reset, scl_in, sda_out, sda_oe, host_low;
  wire logic sda_in;
  logic [7:0] event_pending_in, charger_state_a_in, charger_state_b_in, event_enable;
  logic [3:0] fault_set, input_current_limit, fault_flags;
  logic [5:0] termination_voltage;
  logic [1:0] termination_current, trickle_current, recharge_threshold, dead_battery_threshold;
  logic [2:0] fast_charge_current, weak_battery_threshold, short_timeout_sel, short_voltage_sel;
  ccrb_eoc_t end_of_charge_mode;
  logic complete_timer_enable, charge_timer_enable, charge_timer_period, watchdog_enable, watchdog_period;
  logic watchdog_kick, temp_profile_enable, peak_shutdown_disable, battery_monitor_force;
  logic thermistor_source_force, end_of_charge_enable, trickle_enable, charger_enable, ok;
  logic [7:0] sh [17];
  logic [7:0] q [$];
  int fail_count = 0;
  int num_checks = 0;
  int kick_cycles = 0;
  int exp_kicks = 0;

  // Open-drain data line: low if either party pulls it
  assign sda_in = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  ccrb_top #(.MAKER_CODE(MAKER), .MODEL_CODE(MODEL), .REV_CODE(REV)) dut (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .event_pending_in(event_pending_in), .charger_state_a_in(charger_state_a_in),
    .charger_state_b_in(charger_state_b_in), .fault_set(fault_set), .input_current_limit(input_current_limit),
    .termination_voltage(termination_voltage), .termination_current(termination_current),
    .end_of_charge_mode(end_of_charge_mode), .fast_charge_current(fast_charge_current),
    .trickle_current(trickle_current), .recharge_threshold(recharge_threshold),
    .dead_battery_threshold(dead_battery_threshold), .weak_battery_threshold(weak_battery_threshold),
    .complete_timer_enable(complete_timer_enable), .charge_timer_enable(charge_timer_enable),
    .charge_timer_period(charge_timer_period), .watchdog_enable(watchdog_enable),
    .watchdog_period(watchdog_period), .watchdog_kick(watchdog_kick), .temp_profile_enable(temp_profile_enable),
    .peak_shutdown_disable(peak_shutdown_disable), .battery_monitor_force(battery_monitor_force),
    .thermistor_source_force(thermistor_source_force), .end_of_charge_enable(end_of_charge_enable),
    .trickle_enable(trickle_enable), .charger_enable(charger_enable), .event_enable(event_enable),
    .fault_flags(fault_flags), .short_timeout_sel(short_timeout_sel), .short_voltage_sel(short_voltage_sel));

  ccrb_host_model host (.clk_sys(clk_sys), .sda_line(sda_in), .scl_out(scl_in), .sda_low(host_low));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Count kick cycles; a stretched pulse shows up as an extra count
  always @(posedge clk_sys) begin
    if (watchdog_kick === 1'b1) kick_cycles++;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Read-back value: stored bits plus fixed bits, status bytes pass straight through except bit 3 of state B, masked to zero
  function automatic logic [7:0] expv(input int a);
    if (a == 10) return event_pending_in;
    if (a == 11) return charger_state_a_in;
    if (a == 12) return charger_state_b_in & 8'hF7;
    return FIXV[a] | sh[a];
  endfunction : expv

  // Write one value to n registers in a row and track what each should now hold
  task automatic wr_run(input logic [7:0] sub, input logic [7:0] p, input int n);
    q = {};
    for (int a = sub; a < sub + n; a++) begin
      q.push_back(p);
      if (a == 13) sh[a] = sh[a] & ~(p & 8'h0F);
      else if (a < 17) sh[a] = p & WMSK[a];
      if (a == 6) exp_kicks += p[0];
    end
    host.wr(DEV_ADDR, sub, q, ok);
    check(ok, 1'b1, "write ack");
  endtask : wr_run

  // Read the whole map in one burst and compare every byte
  task automatic read_all();
    host.rd(8'h00, 17, q, ok);
    check(ok, 1'b1, "read ack");
    for (int a = 0; a < 17; a++) check(q[a], expv(a), "read byte");
  endtask : read_all

  // Configuration outputs must follow the stored fields
  task automatic check_outs();
    check(input_current_limit, sh[2][3:0], "input limit");
    check({termination_voltage, termination_current}, sh[3], "term");
    check(end_of_charge_mode, sh[4][7] ? EOC_C20 : (sh[4][6] ? EOC_C10 : EOC_FIXED), "eoc");
    check({fast_charge_current, trickle_current}, sh[4][4:0], "chg");
    check({recharge_threshold, dead_battery_threshold, weak_battery_threshold}, sh[5][6:0], "vth");
    check({complete_timer_enable, charge_timer_enable, charge_timer_period, watchdog_enable, watchdog_period},
      sh[6][5:1], "tmr");
    check({temp_profile_enable, peak_shutdown_disable, battery_monitor_force, thermistor_source_force,
      end_of_charge_enable, trickle_enable, charger_enable}, {sh[7][7:4], sh[7][2:0]}, "fun");
    check(event_enable, sh[9], "even");
    check(fault_flags, sh[13][3:0], "fault");
    check({short_timeout_sel, short_voltage_sel}, {sh[16][7:5], sh[16][2:0]}, "short");
    check(kick_cycles, exp_kicks, "kick");
  endtask : check_outs

  // Hang guard: runs out only if the sequence stalls
  initial begin
    repeat (80000) @(posedge clk_sys);
    fail_count++;
    $display("ERROR t=%0t run did not finish", $time);
    conclude();
  end

  initial begin
    reset = 1'b1;
    fault_set = 4'h0;
    event_pending_in = 8'h5A;
    charger_state_a_in = 8'hC3;
    charger_state_b_in = 8'hFF;
    sh = RSTV;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    read_all();
    check_outs();
    $display("test reset values done");
    // Every pattern written over the whole map, kick bit set in two of them
    foreach (PATS[i]) begin
      wr_run(8'h00, PATS[i], 17);
      read_all();
      check_outs();
      $display("test pattern %h done", PATS[i]);
    end
    // Fault bits set by the charger, then cleared one by writing a one
    fault_set <= 4'hB;
    @(posedge clk_sys);
    fault_set <= 4'h0;
    sh[13] = 8'h0B;
    repeat (2) @(posedge clk_sys);
    check(fault_flags, 4'hB, "fault set");
    wr_run(8'h0D, 8'h02, 1);
    read_all();
    check_outs();
    $display("test fault clear done");
    // A foreign address must not be answered nor change anything
    q = {8'hFF};
    host.wr(7'h15, 8'h03, q, ok);
    check(ok, 1'b0, "foreign address");
    read_all();
    $display("test foreign address done");
    // Power loss in mid-run restores every default
    wr_run(8'h02, 8'hFF, 6);
    check_outs();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    sh = RSTV;
    repeat (6) @(posedge clk_sys);
    read_all();
    check_outs();
    $display("test power loss done");
    conclude();
  end
endmodule : ccrb_top_tb_top
